// ===== hdl/pll_config_status_fields.sv
// dual pll configuration and status bank behind an apb slave
//
// Design decisions made here: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
module pll_config_status_fields (
   input wire logic core_clk, // 40 MHz core clock
   input wire logic rst, // asynchronous reset, active high
   // apb slave
   input wire logic psel, // select
   input wire logic penable, // access phase
   input wire logic pwrite, // write when high
   input wire logic [pll_cfg_pkg::ADDR_W-1:0] paddr, // byte address
   input wire logic [pll_cfg_pkg::DATA_W-1:0] pwdata, // write data
   input wire logic [3:0] pstrb, // byte strobes, lane 0 used
   output logic [pll_cfg_pkg::DATA_W-1:0] prdata, // read data
   output logic pready, // access done
   output logic pslverr, // unmapped address
   // analog status, asynchronous to core_clk
   input wire logic [pll_cfg_pkg::NUM_PLL-1:0] clk0BadIn, // input zero monitor says bad
   input wire logic [pll_cfg_pkg::NUM_PLL-1:0] clk1BadIn, // input one monitor says bad
   input wire logic [pll_cfg_pkg::NUM_PLL-1:0] refBadIn, // reference monitor says bad
   input wire logic [pll_cfg_pkg::NUM_PLL-1:0] lockedIn, // lock detector
   input wire logic [pll_cfg_pkg::NUM_PLL-1:0] holdoverIn, // oscillator control frozen
   input wire logic [pll_cfg_pkg::NUM_PLL-1:0] selectPin, // manual input select pin
   // configuration to the analog loops, one entry per pll
   output logic [pll_cfg_pkg::NUM_PLL-1:0][16:0] refPredivider, // reference predivider
   output logic [pll_cfg_pkg::NUM_PLL-1:0][16:0] lowerLoopFbDivider, // lower loop divider
   output logic [pll_cfg_pkg::NUM_PLL-1:0][7:0] upperLoopFbInteger, // upper integer part
   output logic [pll_cfg_pkg::NUM_PLL-1:0][17:0] upperLoopFbFraction, // upper fraction
   output logic [pll_cfg_pkg::NUM_PLL-1:0][10:0] outputDivider, // output divider
   output logic [pll_cfg_pkg::NUM_PLL-1:0][1:0] pllModeSelect, // loop mode
   output logic [pll_cfg_pkg::NUM_PLL-1:0][1:0] outSignalType, // 0 lvpecl, 1 lvds per pair
   output logic [pll_cfg_pkg::NUM_PLL-1:0][1:0] outDriveEn_n, // low drives pair, high is hi-z
   output logic [pll_cfg_pkg::NUM_PLL-1:0][1:0] upperLoopFilterSetting, // effective filter
   output logic [pll_cfg_pkg::NUM_PLL-1:0] modulatorOrder, // 0 second, 1 third order
   output logic [pll_cfg_pkg::NUM_PLL-1:0] modulatorEnable, // 0 integer, 1 fractional
   output logic [pll_cfg_pkg::NUM_PLL-1:0][1:0] upperLoopPumpCurrent, // effective pump code
   output logic [pll_cfg_pkg::NUM_PLL-1:0] upperLoopPumpReduce, // pump current reduce
   output logic [pll_cfg_pkg::NUM_PLL-1:0][3:0] converterGain, // converter gain, low mode
   output logic [pll_cfg_pkg::NUM_PLL-1:0][1:0] lowerLoopPumpCurrent, // lower pump, low mode
   output logic [pll_cfg_pkg::NUM_PLL-1:0][4:0] converterDivide, // reference divide ratio
   output logic [pll_cfg_pkg::NUM_PLL-1:0][4:0] lockWindowUs, // lock window in us
   output logic [pll_cfg_pkg::NUM_PLL-1:0] referenceDoublerEnable, // double the reference
   output logic [pll_cfg_pkg::NUM_PLL-1:0] activeInput, // input clock in use
   output logic [pll_cfg_pkg::NUM_PLL-1:0] lockPin // lock indicator pin
);
   import pll_cfg_pkg::*;

   // ======================================================================
   // state of the whole block
   typedef struct packed {
      pll_cfg_s [NUM_PLL-1:0] cfg; // software written fields
      logic [NUM_PLL-1:0][SI_W-1:0] sync1; // first stage, read only by sync2
      logic [NUM_PLL-1:0][SI_W-1:0] sync2; // second stage
      logic [NUM_PLL-1:0][SI_W-1:0] sync3; // third stage
      logic [NUM_PLL-1:0][SI_W-1:0] status; // settled status values
      logic [NUM_PLL-1:0] active; // input in use
      logic [NUM_PLL-1:0][1:0] driveEn_n; // pair drive enables
      logic [NUM_PLL-1:0][1:0] loopFilter; // effective filter setting
      logic [NUM_PLL-1:0][1:0] upperPump; // effective pump code
      logic [NUM_PLL-1:0][4:0] convDiv; // sample rate divide ratio
      logic [NUM_PLL-1:0][4:0] lockWin; // lock window in microseconds
      logic [DATA_W-1:0] rdata; // read data for the access phase
      logic ready; // access phase answer
      logic slvErr; // unmapped flag for the access phase
   } state_s;

   localparam state_s STATE_RESET = '{
      cfg: {NUM_PLL{CFG_RESET}}, sync1: '0, sync2: '0, sync3: '0, status: '0,
      active: '0, driveEn_n: '1, loopFilter: '0, upperPump: '0,
      convDiv: '0, lockWin: '0, rdata: '0, ready: 1'b0, slvErr: 1'b0};

   state_s state_ff; // registered state
   state_s nxt_state; // next state

   // raw asynchronous status gathered per pll
   logic [NUM_PLL-1:0][SI_W-1:0] rawStatus; // unsynchronised monitor levels

   // ======================================================================
   // input gathering
   always_comb begin
      for (int p = 0; p < NUM_PLL; p++) begin
         rawStatus[p] = '0;
         rawStatus[p][SI_INPUT_CLOCK_ZERO_BAD] = clk0BadIn[p];
         rawStatus[p][SI_INPUT_CLOCK_ONE_BAD] = clk1BadIn[p];
         rawStatus[p][SI_REF_BAD] = refBadIn[p];
         rawStatus[p][SI_LOCKED] = lockedIn[p];
         rawStatus[p][SI_HOLDOVER] = holdoverIn[p];
         rawStatus[p][SI_SEL_PIN] = selectPin[p];
      end
   end

   // ======================================================================
   // read byte assembly for one bank
   function automatic logic [7:0] readByte(input pll_cfg_s c, input logic [SI_W-1:0] st,
                                           input logic act, input logic [5:0] idx);
      logic [7:0] b;
      b = '0;
      unique case (idx)
         REG_FRAC_HI: b = c.fbFraction[17:10];
         REG_FRAC_MID: b = c.fbFraction[9:2];
         REG_FRAC_INT: b = {c.fbFraction[1:0], c.fbInteger[7:2]};
         REG_INT_PRE: b = {c.fbInteger[1:0], c.predivider[16:11]};
         REG_PRE_MID: b = c.predivider[10:3];
         REG_PRE_LOWER: b = {c.predivider[2:0], c.lowerFbDivider[16:12]};
         REG_LOWER_MID: b = c.lowerFbDivider[11:4];
         REG_LOWER_OUT: b = {c.lowerFbDivider[3:0], c.outputDivider[10:7]};
         REG_OUT_LOOP: b = {c.outputDivider[6:0], c.loopSettings[6]};
         REG_LOOP_TYPE: b = {c.loopSettings[5:0], c.out1SignalType, c.out0SignalType};
         REG_MODE_OE: b = {c.mode, MODE_OE_FIXED, c.out1Enable, c.out0Enable, 2'h0};
         REG_SELECT: b = {c.inputSelectBit, c.policy, 1'b0, c.sampleRate, c.lockWindow};
         REG_DOUBLER: b = {DOUBLER_FIXED_HI, c.doubler, DOUBLER_FIXED_LO};
         // status byte is read only and built from the live flags
         REG_STATUS: b = {act, st[SI_HOLDOVER], st[SI_INPUT_CLOCK_ONE_BAD], st[SI_INPUT_CLOCK_ZERO_BAD],
                          st[SI_REF_BAD], st[SI_LOCKED], 2'h0};
         default: b = '0; // odd reserved registers read zero
      endcase
      return b;
   endfunction : readByte

   // ======================================================================
   // write byte placement for one bank; reserved and fixed bits dropped
   function automatic pll_cfg_s writeByte(input pll_cfg_s c, input logic [5:0] idx,
                                          input logic [7:0] b);
      pll_cfg_s n;
      n = c;
      unique case (idx)
         REG_FRAC_HI: n.fbFraction[17:10] = b;
         REG_FRAC_MID: n.fbFraction[9:2] = b;
         REG_FRAC_INT: {n.fbFraction[1:0], n.fbInteger[7:2]} = b;
         REG_INT_PRE: {n.fbInteger[1:0], n.predivider[16:11]} = b;
         REG_PRE_MID: n.predivider[10:3] = b;
         REG_PRE_LOWER: {n.predivider[2:0], n.lowerFbDivider[16:12]} = b;
         REG_LOWER_MID: n.lowerFbDivider[11:4] = b;
         REG_LOWER_OUT: {n.lowerFbDivider[3:0], n.outputDivider[10:7]} = b;
         REG_OUT_LOOP: {n.outputDivider[6:0], n.loopSettings[6]} = b;
         REG_LOOP_TYPE: {n.loopSettings[5:0], n.out1SignalType, n.out0SignalType} = b;
         REG_MODE_OE: begin
            n.mode = pll_mode_e'(b[7:6]);
            {n.out1Enable, n.out0Enable} = b[3:2];
         end
         REG_SELECT: begin
            n.inputSelectBit = b[7];
            n.policy = select_policy_e'(b[6:5]);
            n.sampleRate = b[3:2];
            n.lockWindow = b[1:0];
         end
         REG_DOUBLER: n.doubler = b[3];
         default: n = c; // status and reserved: writes ignored
      endcase
      return n;
   endfunction : writeByte

   // ======================================================================
   // next state
   always_comb begin
      logic [5:0] idx;
      logic bank;
      logic mapped;
      logic setup;
      logic doWrite;
      logic [1:0] bad;
      logic prim;
      logic cur;
      idx = paddr[7:2];
      bank = paddr[PLL_SEL_BIT];
      mapped = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:PLL_SEL_BIT+1] == '0)
               && (idx <= REG_LAST);
      setup = psel && !penable;
      doWrite = psel && penable && state_ff.ready && pwrite && mapped && pstrb[0];
      bad = '0;
      prim = 1'b0;
      cur = 1'b0;
      nxt_state = state_ff;

      // three stage sampling; a change counts once stages two and three agree
      nxt_state.sync1 = rawStatus;
      nxt_state.sync2 = state_ff.sync1;
      nxt_state.sync3 = state_ff.sync2;
      for (int p = 0; p < NUM_PLL; p++) begin
         for (int i = 0; i < SI_W; i++) begin
            if (state_ff.sync2[p][i] == state_ff.sync3[p][i]) begin
               // flags track the monitor, so they clear themselves
               nxt_state.status[p][i] = state_ff.sync3[p][i];
            end
         end
      end

      // apb: answer one cycle after setup, data taken from the bank at setup
      nxt_state.ready = setup;
      nxt_state.slvErr = setup && !mapped;
      if (setup) begin
         // each bank is its own target inside the window
         nxt_state.rdata = (mapped && !pwrite)
            ? {{(DATA_W-8){1'b0}},
               readByte(state_ff.cfg[bank], state_ff.status[bank], state_ff.active[bank], idx)}
            : '0;
      end else if (!psel) begin
         nxt_state.rdata = '0;
      end
      if (doWrite) begin
         // reserved bit content is the host's duty; it is dropped here anyway
         nxt_state.cfg[bank] = writeByte(state_ff.cfg[bank], idx, pwdata[7:0]);
      end

      // per pll derived outputs
      for (int p = 0; p < NUM_PLL; p++) begin
         bad = {state_ff.status[p][SI_INPUT_CLOCK_ONE_BAD], state_ff.status[p][SI_INPUT_CLOCK_ZERO_BAD]};
         prim = state_ff.cfg[p].inputSelectBit;
         cur = state_ff.active[p];
         // input selection follows the policy
         unique case (state_ff.cfg[p].policy)
            SEL_PIN_MANUAL: cur = state_ff.status[p][SI_SEL_PIN]; // bit ignored
            SEL_REG_MANUAL: cur = prim;
            SEL_AUTO_NONREV: begin
               // stays on the survivor even after the primary recovers
               if (bad[cur] && !bad[!cur]) begin
                  cur = !cur;
               end
            end
            SEL_AUTO_REV: begin
               // returns to the primary as soon as it is good again
               if (!bad[prim]) begin
                  cur = prim;
               end else if (!bad[!prim]) begin
                  cur = !prim;
               end
            end
         endcase
         nxt_state.active[p] = cur;
         // disabled pairs float
         nxt_state.driveEn_n[p] = ~{state_ff.cfg[p].out1Enable, state_ff.cfg[p].out0Enable};
         if (state_ff.cfg[p].mode == MODE_LOW_BW) begin
            nxt_state.loopFilter[p] = 2'h0;
            nxt_state.upperPump[p] = 2'h0;
         end else begin
            nxt_state.loopFilter[p] = state_ff.cfg[p].loopSettings[6:5];
            nxt_state.upperPump[p] = state_ff.cfg[p].loopSettings[2:1];
         end
         // divide ratio 16, 8, 4, 2; the doubler does not change it here
         nxt_state.convDiv[p] = CONV_DIV_MAX >> state_ff.cfg[p].sampleRate;
         nxt_state.lockWin[p] = LOCK_WIN_MIN_US << state_ff.cfg[p].lockWindow;
      end
   end

   // ======================================================================
   // state register; reset loads constants only
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_ff <= STATE_RESET;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // ======================================================================
   // outputs, all taken straight from flip-flops
   assign prdata = state_ff.rdata;
   assign pready = state_ff.ready;
   assign pslverr = state_ff.slvErr;

   // field fan-out per pll
   always_comb begin
      for (int p = 0; p < NUM_PLL; p++) begin
         refPredivider[p] = state_ff.cfg[p].predivider;
         lowerLoopFbDivider[p] = state_ff.cfg[p].lowerFbDivider;
         upperLoopFbInteger[p] = state_ff.cfg[p].fbInteger;
         upperLoopFbFraction[p] = state_ff.cfg[p].fbFraction;
         outputDivider[p] = state_ff.cfg[p].outputDivider;
         pllModeSelect[p] = state_ff.cfg[p].mode;
         outSignalType[p] = {state_ff.cfg[p].out1SignalType,
                             state_ff.cfg[p].out0SignalType};
         outDriveEn_n[p] = state_ff.driveEn_n[p];
         upperLoopFilterSetting[p] = state_ff.loopFilter[p];
         modulatorOrder[p] = state_ff.cfg[p].loopSettings[4];
         modulatorEnable[p] = state_ff.cfg[p].loopSettings[3];
         upperLoopPumpCurrent[p] = state_ff.upperPump[p];
         upperLoopPumpReduce[p] = state_ff.cfg[p].loopSettings[0];
         converterGain[p] = state_ff.cfg[p].loopSettings[6:3];
         lowerLoopPumpCurrent[p] = state_ff.cfg[p].loopSettings[2:1];
         converterDivide[p] = state_ff.convDiv[p];
         lockWindowUs[p] = state_ff.lockWin[p];
         referenceDoublerEnable[p] = state_ff.cfg[p].doubler;
         activeInput[p] = state_ff.active[p];
         lockPin[p] = state_ff.status[p][SI_LOCKED];
      end
   end

endmodule : pll_config_status_fields

// ===== pkg/pll_cfg_pkg.sv
// shared constants, field layouts and types for the dual pll configuration bank
// ==========================================================================
// Functional notes
// - type bit picks lvpecl 0, lvds 1
// - reference predivider is 17 bits wide
// - lower loop feedback divider 17 bits
// - upper divider: 8-bit integer, 18-bit fraction
// - output divider is 11 bits wide
// - mode 00 low, 01 synth, else high
// - per pair enable, 0 off, 1 on
// - policy pin, auto nonrevertive, auto revertive, register
// - select bit: register pick, auto primary, pin ignored; the auto nonrevertive policy here ignores it as well
// - sample rate code divides reference by 16..2
// - lock window code gives 2..16 microseconds
// - doubler bit doubles reference before detector
// - input fault flags follow input, self clearing
// - reference fault flag follows reference, self clearing
// - lock flag mirrored on lock pin
// - holdover flag shows frozen oscillator control
// - active input flag follows failover switching
// - loop settings field layout depends on mode
// - modulator enable and order bit meanings
// - upper pump 11 reserved, 00 in low mode
// - upper loop filter forced 00 in low mode
// - disabled output pair goes high impedance
// - two identical pll banks, separate bus targets
package pll_cfg_pkg;

   // ======================================================================
   // bus geometry
   localparam int unsigned NUM_PLL = 2; // two independent loops
   localparam int unsigned ADDR_W = 12; // apb byte address width
   localparam int unsigned DATA_W = 32; // apb data width
   localparam int unsigned PLL_SEL_BIT = 8; // byte address bit picking the pll bank
   localparam int unsigned REG_COUNT = 24; // byte registers per bank
   localparam logic [5:0] REG_LAST = 6'h17; // highest register index

   // register indices (byte address is four times the index)
   localparam logic [5:0] REG_FRAC_HI = 6'h00;
   localparam logic [5:0] REG_FRAC_MID = 6'h02;
   localparam logic [5:0] REG_FRAC_INT = 6'h04;
   localparam logic [5:0] REG_INT_PRE = 6'h06;
   localparam logic [5:0] REG_PRE_MID = 6'h08;
   localparam logic [5:0] REG_PRE_LOWER = 6'h0a;
   localparam logic [5:0] REG_LOWER_MID = 6'h0c;
   localparam logic [5:0] REG_LOWER_OUT = 6'h0e;
   localparam logic [5:0] REG_OUT_LOOP = 6'h10;
   localparam logic [5:0] REG_LOOP_TYPE = 6'h12;
   localparam logic [5:0] REG_MODE_OE = 6'h14;
   localparam logic [5:0] REG_SELECT = 6'h15;
   localparam logic [5:0] REG_DOUBLER = 6'h16;
   localparam logic [5:0] REG_STATUS = 6'h17;

   // fixed bits that read back in the mode and doubler registers
   localparam logic [1:0] MODE_OE_FIXED = 2'h1;
   localparam logic [3:0] DOUBLER_FIXED_HI = 4'ha;
   localparam logic [2:0] DOUBLER_FIXED_LO = 3'h1;

   // ======================================================================
   // modes and policies
   typedef enum logic [1:0] {
      MODE_LOW_BW = 2'b00,
      MODE_SYNTH = 2'b01,
      MODE_HIGH_BW = 2'b10,
      MODE_HIGH_BW_ALT = 2'b11
   } pll_mode_e;

   typedef enum logic [1:0] {
      SEL_PIN_MANUAL = 2'b00,
      SEL_AUTO_NONREV = 2'b01,
      SEL_AUTO_REV = 2'b10,
      SEL_REG_MANUAL = 2'b11
   } select_policy_e;

   // synchronised status input positions
   localparam int unsigned SI_INPUT_CLOCK_ZERO_BAD = 0;
   localparam int unsigned SI_INPUT_CLOCK_ONE_BAD = 1;
   localparam int unsigned SI_REF_BAD = 2;
   localparam int unsigned SI_LOCKED = 3;
   localparam int unsigned SI_HOLDOVER = 4;
   localparam int unsigned SI_SEL_PIN = 5;
   localparam int unsigned SI_W = 6;

   // converter rate base and lock window base
   localparam logic [4:0] CONV_DIV_MAX = 5'h10; // divide by 16 at code 00
   localparam logic [4:0] LOCK_WIN_MIN_US = 5'h02; // 2 us at code 00

   // ======================================================================
   // per pll configuration fields
   typedef struct packed {
      logic [17:0] fbFraction;
      logic [7:0] fbInteger;
      logic [16:0] predivider;
      logic [16:0] lowerFbDivider;
      logic [10:0] outputDivider;
      logic [6:0] loopSettings;
      logic out1SignalType;
      logic out0SignalType;
      pll_mode_e mode;
      logic out1Enable;
      logic out0Enable;
      logic inputSelectBit;
      select_policy_e policy;
      logic [1:0] sampleRate;
      logic [1:0] lockWindow;
      logic doubler;
   } pll_cfg_s;

   // power-up defaults of the configuration bank
   localparam pll_cfg_s CFG_RESET = '{
      fbFraction: 18'h00000, fbInteger: 8'h00, predivider: 17'h00001,
      lowerFbDivider: 17'h00001, outputDivider: 11'h001, loopSettings: 7'h00,
      out1SignalType: 1'b0, out0SignalType: 1'b0, mode: MODE_LOW_BW,
      out1Enable: 1'b0, out0Enable: 1'b0, inputSelectBit: 1'b0,
      policy: SEL_PIN_MANUAL, sampleRate: 2'h2, lockWindow: 2'h0, doubler: 1'b0};

endpackage : pll_cfg_pkg

// ===== bench/pll_cfg_chk.sv
// assertions on the bus side and derived controls of the pll bank
`timescale 1ns/100ps
module pll_cfg_chk
   import pll_cfg_pkg::*;
(
   input wire logic core_clk, // clock
   input wire logic rst, // reset
   input wire logic psel, // select
   input wire logic penable, // access
   input wire logic pwrite, // write
   input wire logic [pll_cfg_pkg::ADDR_W-1:0] paddr, // address
   input wire logic [pll_cfg_pkg::DATA_W-1:0] pwdata, // write data
   input wire logic [pll_cfg_pkg::DATA_W-1:0] prdata, // read data
   input wire logic pready, // done
   input wire logic pslverr, // error
   input wire logic [pll_cfg_pkg::NUM_PLL-1:0][1:0] outDriveEn_n, // pair drive
   input wire logic [pll_cfg_pkg::NUM_PLL-1:0][1:0] pllModeSelect, // mode
   input wire logic [pll_cfg_pkg::NUM_PLL-1:0][1:0] upperLoopFilterSetting, // filter
   input wire logic [pll_cfg_pkg::NUM_PLL-1:0][1:0] upperLoopPumpCurrent, // pump
   input wire logic [pll_cfg_pkg::NUM_PLL-1:0][4:0] converterDivide, // divide
   input wire logic [pll_cfg_pkg::NUM_PLL-1:0][4:0] lockWindowUs // window
);
   // ====
   // properties on the core clock
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   sequence setupPhase; psel && !penable; endsequence
   // derived outputs land one edge after the field, so checks wait two
   sequence writeDone(a); psel && penable && pready && pwrite && paddr == a; endsequence
   ready_after_setup_a: assert property (setupPhase |=> pready && penable)
      else $error("no ready after setup");
   ready_one_cycle_a: assert property (pready |=> !pready)
      else $error("ready held");
   unmapped_error_a: assert property ((setupPhase and (paddr[11:9] != 3'h0)) |=> pslverr)
      else $error("unmapped not flagged");
   error_with_ready_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   idle_read_zero_a: assert property (!psel && $past(psel) == 1'b0 |-> prdata == 32'h0)
      else $error("read data not cleared");
   drive_follows_enable_a: assert property (writeDone(12'h050) |-> ##2
      outDriveEn_n[0] == ~$past(pwdata[3:2], 2)) else $error("pair drive wrong");
   rate_and_window_a: assert property (writeDone(12'h054) |-> ##2
      converterDivide[0] == (5'h10 >> $past(pwdata[3:2], 2))
      && lockWindowUs[0] == (5'h02 << $past(pwdata[1:0], 2))) else $error("rate wrong");
   low_mode_force_a: assert property (pllModeSelect[0] == 2'h0
      && $past(pllModeSelect[0]) == 2'h0 |-> upperLoopFilterSetting[0] == 2'h0
      && upperLoopPumpCurrent[0] == 2'h0) else $error("low mode not forced");
endmodule : pll_cfg_chk
bind pll_config_status_fields pll_cfg_chk i_pll_cfg_chk (.core_clk(core_clk), .rst(rst),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .outDriveEn_n(outDriveEn_n),
   .pllModeSelect(pllModeSelect), .upperLoopFilterSetting(upperLoopFilterSetting),
   .upperLoopPumpCurrent(upperLoopPumpCurrent), .converterDivide(converterDivide),
   .lockWindowUs(lockWindowUs));

// ===== bench/apb_host.sv
// host model programming the pll bank one byte register at a time
`timescale 1ns/100ps
module apb_host (
   input wire logic core_clk, // clock
   input wire logic [31:0] prdata, // read data
   input wire logic pready, // done
   input wire logic pslverr, // error
   output logic psel, // select
   output logic penable, // access
   output logic pwrite, // write
   output logic [11:0] paddr, // address
   output logic [31:0] pwdata, // write data
   output logic [3:0] pstrb // strobes
);
   // ====
   // bus idle from time zero
   initial {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
   // request stands until pready is seen high at an edge
   task automatic xfer(input logic wr, input logic [11:0] a, input logic [7:0] d,
      output logic [7:0] q, output logic err);
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h000000, d}; // unused lanes sent as zero
      pstrb <= 4'h1;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      q = prdata[7:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
endmodule : apb_host

// ===== bench/pll_config_status_fields_test.sv
// self-checking bench for the dual pll configuration bank
`timescale 1ns/100ps
module pll_config_status_fields_test;
   // ====
   // clock, reset, bus, status and loop controls
   logic core_clk = 1'b0, rst = 1'b1, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0] pstrb;
   logic [1:0] clk0BadIn = '0, clk1BadIn = '0, refBadIn = '0, lockedIn = '0, holdoverIn = '0;
   logic [1:0] selectPin = '0, modulatorOrder, modulatorEnable, upperLoopPumpReduce;
   logic [1:0] referenceDoublerEnable, activeInput, lockPin;
   logic [1:0][16:0] refPredivider, lowerLoopFbDivider;
   logic [1:0][17:0] upperLoopFbFraction;
   logic [1:0][10:0] outputDivider;
   logic [1:0][7:0] upperLoopFbInteger;
   logic [1:0][4:0] converterDivide, lockWindowUs;
   logic [1:0][3:0] converterGain;
   logic [1:0][1:0] pllModeSelect, outSignalType, outDriveEn_n, upperLoopFilterSetting;
   logic [1:0][1:0] upperLoopPumpCurrent, lowerLoopPumpCurrent;
   int errors = 0, totalChecks = 0, cycles = 0;
   initial forever #12.5 core_clk = ~core_clk;
   pll_config_status_fields i_pll_config_status_fields (.*);
   apb_host i_apb_host (.*);
   // verdict and end of run
   task automatic end_of_test;
      if (errors == 0 && totalChecks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : end_of_test
   // run needs under two hundred cycles, so a hang is cut well above that
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 3000) begin
         errors++;
         end_of_test();
      end
   end
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      totalChecks++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   // write, then let the derived outputs settle
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic [7:0] q;
      logic e;
      i_apb_host.xfer(1'b1, a, d, q, e);
      repeat (2) @(negedge core_clk);
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [7:0] exp, input string nm);
      logic [7:0] q;
      logic e;
      i_apb_host.xfer(1'b0, a, 8'h00, q, e);
      chk(nm, 32'(exp), 32'(q));
      chk("error flag", 32'(a[11:9] != 3'h0), 32'(e));
   endtask : rd
   // ====
   // main sequence
   initial begin
      logic [71:0] v;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      rd(12'h050, 8'h10, "mode reg");
      rd(12'h058, 8'ha1, "doubler reg");
      chk("drive off", 32'hf, 32'(outDriveEn_n));
      for (int m = 0; m < 4; m++) begin
         wr(12'h050, {m[1:0], 2'b01, m[1:0], 2'b00});
         chk("mode", 32'(m), 32'(pllModeSelect[0]));
         chk("drive", {30'h0, ~m[1:0]}, 32'(outDriveEn_n[0]));
         chk("mode b", 32'h0, 32'(pllModeSelect[1]));
      end
      v = {18'h2a5c3, 8'hb7, 17'h15a3c, 17'h0c3a5, 11'h5e1, 1'b0};
      for (int k = 0; k < 9; k++)
         wr(12'h100 + 12'(8 * k), v[71 - 8 * k -: 8]);
      chk("fraction", 32'h2a5c3, 32'(upperLoopFbFraction[1]));
      chk("integer", 32'hb7, 32'(upperLoopFbInteger[1]));
      chk("predivider", 32'h15a3c, 32'(refPredivider[1]));
      chk("lower div", 32'h0c3a5, 32'(lowerLoopFbDivider[1]));
      chk("out div", 32'h5e1, 32'(outputDivider[1]));
      wr(12'h040, 8'h01);
      wr(12'h048, 8'h6e);
      chk("pair type", 32'h2, 32'(outSignalType[0]));
      chk("loop high", 32'h5b, 32'({upperLoopFilterSetting[0], modulatorOrder[0],
         modulatorEnable[0], upperLoopPumpCurrent[0], upperLoopPumpReduce[0]}));
      wr(12'h050, 8'h10);
      chk("loop low", 32'h2d, 32'({upperLoopFilterSetting[0], upperLoopPumpCurrent[0],
         converterGain[0], lowerLoopPumpCurrent[0]}));
      for (int c = 0; c < 4; c++) begin
         wr(12'h054, {4'he, c[1:0], c[1:0]});
         chk("divide", 32'h10 >> c, 32'(converterDivide[0]));
         chk("window", 32'h2 << c, 32'(lockWindowUs[0]));
      end
      chk("reg pick", 32'h1, 32'(activeInput[0]));
      wr(12'h058, 8'ha9);
      chk("doubler", 32'h1, 32'(referenceDoublerEnable[0]));
      wr(12'h054, 8'h48);
      @(posedge core_clk);
      clk0BadIn <= 2'b01;
      refBadIn <= 2'b01;
      lockedIn <= 2'b01;
      holdoverIn <= 2'b10;
      repeat (8) @(negedge core_clk);
      chk("lock pin", 32'h1, 32'(lockPin));
      wr(12'h05c, 8'h00);
      rd(12'h05c, 8'h9c, "status a");
      rd(12'h15c, 8'h40, "status b");
      @(posedge core_clk);
      clk0BadIn <= 2'b00;
      selectPin <= 2'b10;
      repeat (8) @(negedge core_clk);
      chk("revert pin", 32'h2, 32'(activeInput));
      rd(12'h05c, 8'h0c, "status clear");
      // non-revertive policy must stay on the survivor after recovery
      wr(12'h054, 8'h28);
      @(posedge core_clk);
      clk0BadIn <= 2'b01;
      repeat (8) @(negedge core_clk);
      chk("fail over", 32'h1, 32'(activeInput[0]));
      @(posedge core_clk);
      clk0BadIn <= 2'b00;
      clk1BadIn <= 2'b10;
      repeat (8) @(negedge core_clk);
      chk("no revert", 32'h3, 32'(activeInput));
      rd(12'h15c, 8'he0, "status b bad");
      rd(12'h200, 8'h00, "unmapped");
      end_of_test();
   end
endmodule : pll_config_status_fields_test
